/* motion_route_sequencer.sv */
// Positioning-route sequencer: eight route records, a homing record,
// parameter tables, ordering of consecutive routes, APB register access.
// Assumes one 40 MHz clock, pins asynchronous, profile side synchronous.
`timescale 1ns/1ps
module motion_route_sequencer
  import mrs_pkg::*;
#(
  parameter int unsigned cyc_per_ms = CYC_PER_MS
) (
  input  wire logic              clk,          // System clock
  input  wire logic              nrst,         // Async reset, active low
  input  wire logic              psel,         // APB select
  input  wire logic              penable,      // APB enable
  input  wire logic              pwrite,       // APB write
  input  wire logic [ADDR_W-1:0] paddr,        // APB byte address
  input  wire logic [31:0]       pwdata,       // APB write data
  output logic      [31:0]       prdata,       // APB read data
  output logic                   pready,       // APB ready
  output logic                   pslverr,      // APB error
  input  wire logic              route_trigger_input,      // Pin
  input  wire logic [SEL_W-1:0]  route_select_inputs,      // Pins
  input  wire logic              motor_halt_input,         // Pin
  input  wire logic              forward_soft_limit_input, // Pin
  input  wire logic              reverse_soft_limit_input, // Pin
  input  wire logic              homing_start_input,       // Pin
  input  wire logic              servo_on,     // Pin, servo enabled
  input  wire logic              cmd_done,     // Position command done
  input  wire logic              home_found,   // Reference found
  output cmd_t                   cmd,          // Commanded move
  output logic                   cmd_load,     // New command pulse
  output logic                   halt_req,     // Stop pulse
  output logic                   homing_req,   // Start homing pulse
  output state_t                 seq_state,    // Sequencer state
  output logic [3:0]             active_route, // Route 1..8, 0 none
  output logic                   limit_stop    // Stopped by soft limit
);

  localparam logic [15:0] SUB_LAST = 16'(cyc_per_ms - 1);

  typedef struct packed {
    state_t                      st;
    cmd_t                        cmd;
    logic                        cmd_load;
    logic                        halt_req;
    logic                        homing_req;
    logic [3:0]                  cur_route;
    logic                        cur_overlap_next;
    logic [15:0]                 cur_dwell;
    logic                        pend;
    logic [2:0]                  pend_idx;
    logic [15:0]                 ms_cnt;
    logic [15:0]                 sub_cnt;
    logic                        booted;
    logic                        limit_stop;
    pin_t                        prev;
    logic [31:0]                 home_ctrl;
    logic [31:0]                 home_coord;
    logic [ROUTES-1:0][1:0][31:0] route;
    logic [TAB_N-1:0][15:0]      spd_tab;
    logic [TAB_N-1:0][15:0]      acc_tab;
    logic [TAB_N-1:0][15:0]      dly_tab;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
  } sq_t;

  localparam sq_t SQ_RST = '{st: ST_IDLE, default: '0};

  sq_t              r;
  sq_t              n;
  pin_t             pin_s;
  logic [PIN_W-1:0] pin_raw;
  logic [31:0]      rd_data;
  logic             hit;
  logic             launch_en;
  logic [2:0]       launch_idx;
  logic             launch_ovl;
  logic [31:0]      base_pos;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] nib(logic [31:0] w, int pos);
    return w[pos+:4];
  endfunction : nib

  // Load a route into the command and start running it
  function automatic sq_t launch(sq_t s, logic [2:0] i, logic ovl);
    sq_t         o;
    logic [31:0] w0;
    logic [31:0] tg;
    o  = s;
    w0 = s.route[i][0];
    tg = s.route[i][1];
    case (w0[F_CTYPE+:2])
      CT_INCR:  o.cmd.end_pos = s.cmd.end_pos + tg;
      CT_SPEED: o.cmd.end_pos = s.cmd.end_pos;
      default:  o.cmd.end_pos = tg;
    endcase
    o.cmd.speed      = s.spd_tab[nib(w0, F_SPEED)];
    o.cmd.accel      = s.acc_tab[nib(w0, F_ACCEL)];
    o.cmd.decel      = s.acc_tab[nib(w0, F_DECEL)];
    o.cmd.speed_mode = (w0[F_CTYPE+:2] == CT_SPEED);
    o.cmd.blend      = ovl & (w0[F_CTYPE+:2] != CT_SPEED);
    o.cur_dwell      = s.dly_tab[nib(w0, F_DWELL)];
    o.cur_overlap_next       = w0[F_OVERLAP_NEXT];
    o.cur_route      = {1'b0, i} + 4'h1;
    o.st             = ST_RUN;
    o.cmd_load       = 1'b1;
    o.limit_stop     = 1'b0;
    return o;
  endfunction : launch

  // ---------------------------------------------------------------
  // Pin sampling and event decode
  // ---------------------------------------------------------------
  assign pin_raw = {route_trigger_input, motor_halt_input,
                    forward_soft_limit_input, reverse_soft_limit_input,
                    homing_start_input, servo_on, route_select_inputs};

  pin_sync #(
    .W    (PIN_W)
  ) u_pin_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (pin_raw),
    .dout (pin_s)
  );

  logic             acc;
  logic             wr_en;
  logic [5:0]       region;
  logic             sw_go;
  logic             go;
  logic [SEL_W-1:0] sel;
  logic             sel_route;
  logic [2:0]       idx;
  logic             interrupt_previous;
  logic             halt_rise;
  logic             limit_hit;
  logic             servo_rise;
  logic             home_go;
  logic [3:0]       path;

  assign acc       = psel & penable;
  assign wr_en     = acc & r.pready & pwrite;
  assign region    = paddr[11:6];
  assign sw_go     = wr_en & (paddr == OFS_SW_TRIG)
                   & (pwdata[31:SEL_W] == '0);
  assign go        = sw_go | (pin_s.trig & ~r.prev.trig);
  assign sel       = sw_go ? pwdata[SEL_W-1:0] : pin_s.sel;
  assign sel_route = (sel != '0) && (sel <= SEL_W'(ROUTES));
  assign idx       = 3'(sel - SEL_W'(1));
  assign interrupt_previous       = r.route[idx][0][F_INS];
  assign halt_rise = pin_s.halt & ~r.prev.halt;
  assign limit_hit = pin_s.fwd_lim | pin_s.rev_lim;
  assign servo_rise = pin_s.servo_on & ~r.prev.servo_on;
  assign path      = nib(r.home_ctrl, F_PATH);
  // Boot homing only at the first servo-on after reset, and only if the boot field is one then
  assign home_go   = (go && sel == '0)
                   | (pin_s.home_start & ~r.prev.home_start)
                   | (servo_rise & ~r.booted
                      & (nib(r.home_ctrl, F_BOOT) == BOOT_ON));

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    hit     = 1'b1;
    if (region == RG_ROUTE) begin
      rd_data = r.route[paddr[5:3]][paddr[2]];
    end else if (region == RG_SPEED) begin
      rd_data = {16'h0, r.spd_tab[paddr[5:2]]};
    end else if (region == RG_ACCDEC) begin
      rd_data = {16'h0, r.acc_tab[paddr[5:2]]};
    end else if (region == RG_DWELL) begin
      rd_data = {16'h0, r.dly_tab[paddr[5:2]]};
    end else begin
      case (paddr)
        OFS_HOME_CTRL:  rd_data = r.home_ctrl;
        OFS_HOME_COORD: rd_data = r.home_coord;
        OFS_SW_TRIG:    rd_data = '0;
        OFS_STATUS:     rd_data = {18'h0, r.limit_stop, r.booted,
                                   r.pend_idx, r.pend, r.cur_route, r.st};
        default:        hit = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and register file next state
  // ---------------------------------------------------------------
  always_comb begin
    n            = r;
    launch_en    = 1'b0;
    launch_idx   = '0;
    launch_ovl   = 1'b0;
    base_pos     = '0;
    n.cmd_load   = 1'b0;
    n.halt_req   = 1'b0;
    n.homing_req = 1'b0;
    n.prev       = pin_s;
    if (servo_rise) begin
      n.booted = 1'b1;
    end
    // Stop events first; limits only in run and dwell
    if (halt_rise || (limit_hit &&
        (r.st == ST_RUN || r.st == ST_DWELL))) begin
      n.st         = ST_IDLE;
      n.halt_req   = 1'b1;
      n.pend       = 1'b0;
      n.cmd.blend  = 1'b0;
      n.limit_stop = ~halt_rise;
    end else if (home_go) begin
      n.st         = ST_HOMING;
      n.homing_req = 1'b1;
      n.pend       = 1'b0;
      n.cur_route  = '0;
      n.cmd.blend  = 1'b0;
      n.cmd.accel  = r.acc_tab[nib(r.home_ctrl, F_ACCEL)];
      n.cmd.decel  = r.acc_tab[nib(r.home_ctrl, F_FIRST_DECEL_SELECT)];
      n.limit_stop = 1'b0;
    end else if (go && sel_route && (r.st == ST_IDLE || interrupt_previous)) begin
      launch_en  = 1'b1;
      launch_idx = idx;
      n.pend     = 1'b0;
    end else begin
      if (go && sel_route) begin
        n.pend     = 1'b1;
        n.pend_idx = idx;
      end
      unique case (r.st)
        ST_IDLE: begin
          n.st = ST_IDLE;
        end
        ST_RUN: begin
          if (cmd_done) begin
            if (r.cur_overlap_next || r.cur_dwell == '0) begin
              if (n.pend) begin
                launch_en  = 1'b1;
                launch_idx = n.pend_idx;
                launch_ovl = r.cur_overlap_next;
                n.pend     = 1'b0;
              end else begin
                n.st = ST_IDLE;
              end
            end else begin
              n.st      = ST_DWELL;
              n.ms_cnt  = '0;
              n.sub_cnt = '0;
            end
          end
        end
        ST_DWELL: begin
          if (r.sub_cnt == SUB_LAST) begin
            n.sub_cnt = '0;
            n.ms_cnt  = r.ms_cnt + 16'h1;
            if (r.ms_cnt + 16'h1 == r.cur_dwell) begin
              if (n.pend) begin
                launch_en  = 1'b1;
                launch_idx = n.pend_idx;
                n.pend     = 1'b0;
              end else begin
                n.st = ST_IDLE;
              end
            end
          end else begin
            n.sub_cnt = r.sub_cnt + 16'h1;
          end
        end
        ST_HOMING: begin
          if (home_found) begin
            n.cmd.end_pos = r.home_coord;
            if (path != '0 && path <= 4'(ROUTES)) begin
              launch_en  = 1'b1;
              launch_idx = 3'(path - 4'h1);
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    if (launch_en) begin
      base_pos = n.cmd.end_pos;
      n        = launch(n, launch_idx, launch_ovl);
    end
    // APB: one wait state, write lands with pready
    n.pready  = acc & ~r.pready;
    n.pslverr = 1'b0;
    if (acc && !r.pready) begin
      n.prdata  = rd_data;
      n.pslverr = ~hit;
    end
    if (wr_en && hit) begin
      if (region == RG_ROUTE) begin
        n.route[paddr[5:3]][paddr[2]] = pwdata;
        if (!paddr[2]) begin
          n.route[paddr[5:3]][0][3:0] = 4'h0;
        end
      end else if (region == RG_SPEED) begin
        n.spd_tab[paddr[5:2]] = pwdata[15:0];
      end else if (region == RG_ACCDEC) begin
        n.acc_tab[paddr[5:2]] = pwdata[15:0];
      end else if (region == RG_DWELL) begin
        n.dly_tab[paddr[5:2]] = pwdata[15:0];
      end else if (paddr == OFS_HOME_CTRL) begin
        n.home_ctrl = pwdata;
      end else if (paddr == OFS_HOME_COORD) begin
        n.home_coord = pwdata;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= SQ_RST;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata       = r.prdata;
  assign pready       = r.pready;
  assign pslverr      = r.pslverr;
  assign cmd          = r.cmd;
  assign cmd_load     = r.cmd_load;
  assign halt_req     = r.halt_req;
  assign homing_req   = r.homing_req;
  assign seq_state    = r.st;
  assign active_route = r.cur_route;
  assign limit_stop   = r.limit_stop;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic        quiet;
  logic [31:0] lw0;
  logic [31:0] ltg;

  assign quiet = ~halt_rise & ~limit_hit & ~go & ~home_go;
  assign lw0   = r.route[launch_idx][0];
  assign ltg   = r.route[launch_idx][1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_halt_stops: assert property (
    halt_rise |=> seq_state == ST_IDLE && halt_req && !cmd_load)
    else $error("halt edge did not stop the sequencer");

  a_abs_target: assert property (
    launch_en && lw0[F_CTYPE+:2] == CT_ABS |=>
      cmd_load && cmd.end_pos == $past(ltg))
    else $error("absolute route end position wrong");

  a_incr_sum: assert property (
    launch_en && lw0[F_CTYPE+:2] == CT_INCR |=>
      cmd.end_pos == $past(base_pos) + $past(ltg))
    else $error("incremental route end position wrong");

  a_ins_aborts: assert property (
    r.st == ST_RUN && go && sel_route && interrupt_previous && !halt_rise
      && !limit_hit && !home_go |=>
      cmd_load && active_route == $past(sel[3:0]))
    else $error("interrupt route did not start at once");

  a_dwell_entry: assert property (
    r.st == ST_RUN && cmd_done && !r.cur_overlap_next && r.cur_dwell != '0
      && quiet |=> seq_state == ST_DWELL && !cmd_load)
    else $error("dwell not entered after position done");

  a_overlap_next_nodwell: assert property (
    r.st == ST_RUN && cmd_done && r.cur_overlap_next && quiet |=>
      seq_state != ST_DWELL)
    else $error("overlap route applied a dwell");

  a_limit_halt: assert property (
    r.st == ST_RUN && limit_hit && !halt_rise |=>
      seq_state == ST_IDLE && limit_stop && halt_req)
    else $error("soft limit did not stop the route");

  a_home_stop: assert property (
    r.st == ST_HOMING && home_found && quiet && path == '0 |=>
      seq_state == ST_IDLE && cmd.end_pos == $past(r.home_coord))
    else $error("homing stop mode misbehaved");

  a_home_route: assert property (
    r.st == ST_HOMING && home_found && quiet && path != '0
      && path <= 4'h8 |=> cmd_load && active_route == $past(path))
    else $error("follow-on route not started after homing");

  a_home_nolimit: assert property (
    r.st == ST_HOMING && limit_hit && !halt_rise && !go && !home_go
      && !home_found |=> seq_state == ST_HOMING)
    else $error("soft limit acted during homing");

  c_dwell_then_run: cover property (
    seq_state == ST_DWELL ##1 seq_state == ST_RUN);
  c_overlap_blend: cover property (cmd_load && cmd.blend);
  c_home_to_route: cover property (
    seq_state == ST_HOMING ##1 cmd_load);

endmodule : motion_route_sequencer

/* mrs_pkg.sv */
// Constants and types shared by the route sequencer and its pin sampler.
// Assumes a single 40 MHz clock domain; no timescale in packages.
package mrs_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ROUTES = 8;
  localparam int TAB_N  = 16;
  localparam int ADDR_W = 12;
  localparam int SEL_W  = 6;
  localparam int PIN_W  = 6 + SEL_W;

  // ---------------------------------------------------------------
  // Register byte offsets and regions (region = paddr[11:6])
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_HOME_CTRL  = 12'h000;
  localparam logic [11:0] OFS_HOME_COORD = 12'h004;
  localparam logic [11:0] OFS_SW_TRIG    = 12'h008;
  localparam logic [11:0] OFS_STATUS     = 12'h00c;
  localparam logic [5:0]  RG_ROUTE       = 6'h01;
  localparam logic [5:0]  RG_SPEED       = 6'h02;
  localparam logic [5:0]  RG_ACCDEC      = 6'h03;
  localparam logic [5:0]  RG_DWELL       = 6'h04;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int F_DWELL = 20;
  localparam int F_SPEED = 16;
  localparam int F_DECEL = 12;
  localparam int F_ACCEL = 8;
  localparam int F_CTYPE = 6;
  localparam int F_OVERLAP_NEXT  = 5;
  localparam int F_INS   = 4;
  localparam int F_SECOND_DECEL_SELECT  = 16;
  localparam int F_FIRST_DECEL_SELECT  = 12;
  localparam int F_PATH  = 4;
  localparam int F_BOOT  = 0;

  // Command-type codes and boot enable value
  localparam logic [1:0] CT_ABS   = 2'h0;
  localparam logic [1:0] CT_SPEED = 2'h1;
  localparam logic [1:0] CT_INCR  = 2'h2;
  localparam logic [3:0] BOOT_ON  = 4'h1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 25;
  localparam int MS_NS      = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_DWELL  = 4'b0100,
    ST_HOMING = 4'b1000
  } state_t;

  typedef struct packed {
    logic [31:0] end_pos;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic        speed_mode;
    logic        blend;
  } cmd_t;

  typedef struct packed {
    logic             trig;
    logic             halt;
    logic             fwd_lim;
    logic             rev_lim;
    logic             home_start;
    logic             servo_on;
    logic [SEL_W-1:0] sel;
  } pin_t;

endpackage : mrs_pkg

/* pin_sync.sv */
// Three-stage sampler for pin inputs with agreement filter.
// Assumes asynchronous pins; output moves when stages two and three agree.
`timescale 1ns/1ps
module pin_sync
  import mrs_pkg::*;
#(
  parameter int W = PIN_W
) (
  input  wire logic         clk,  // System clock
  input  wire logic         nrst, // Async reset, active low
  input  wire logic [W-1:0] din,  // Raw pin levels
  output logic      [W-1:0] dout  // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } ss_t;

  ss_t r;
  ss_t n;

  // Shift chain and per-bit agreement
  always_comb begin
    n    = r;
    n.s1 = din;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.o  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.o & (r.s2 ^ r.s3));
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout = r.o;

endmodule : pin_sync

/* route_far_end.sv */
// Far-side model: motion profile that finishes moves and homing.
// Assumes one clock; the bench picks how long each answer takes.
`timescale 1ns/1ps
module route_far_end (
  input  wire logic       clk,        // System clock
  input  wire logic       nrst,       // Reset, active low
  input  wire logic       cmd_load,   // New move command
  input  wire logic       homing_req, // Homing started
  input  wire logic [7:0] lat,        // Answer latency, cycles
  output logic            cmd_done,   // Move finished pulse
  output logic            home_found  // Reference found pulse
);
  logic [7:0] cnt_reg;
  logic       home_reg;
  // Restart the count on each request, pulse the answer at one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg    <= 8'h00;
      home_reg   <= 1'b0;
      cmd_done   <= 1'b0;
      home_found <= 1'b0;
    end else begin
      cmd_done   <= 1'b0;
      home_found <= 1'b0;
      if (cmd_load || homing_req) begin
        cnt_reg  <= lat;
        home_reg <= homing_req && !cmd_load;
      end else if (cnt_reg == 8'h01) begin
        cnt_reg    <= 8'h00;
        cmd_done   <= !home_reg;
        home_found <= home_reg;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : route_far_end

/* motion_route_sequencer_tb.sv */
// Bench for the route sequencer: APB master, pin driver, checks.
// Assumes the far-side model answers after the latency set here.
`timescale 1ns/1ps
module motion_route_sequencer_tb
  import mrs_pkg::*;
;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, pe;
  logic        trg, halt, flim, rlim, hpin, son, done, found;
  logic        cmd_load, halt_req, homing_req, limit_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t1, t2, sp;
  logic [5:0]  sel;
  logic [7:0]  lat;
  logic [3:0]  act;
  state_t      st;
  cmd_t        cmd;
  int          err_total, num_checks, cyc, c0;

  motion_route_sequencer #(.cyc_per_ms(4)) dut (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .route_trigger_input(trg),
    .route_select_inputs(sel), .motor_halt_input(halt),
    .forward_soft_limit_input(flim), .reverse_soft_limit_input(rlim),
    .homing_start_input(hpin), .servo_on(son), .cmd_done(done),
    .home_found(found), .cmd, .cmd_load, .halt_req, .homing_req,
    .seq_state(st), .active_route(act), .limit_stop);
  route_far_end far (.clk, .nrst, .cmd_load, .homing_req, .lat,
    .cmd_done(done), .home_found(found));

  // --------------------------------------------------------------
  // Clock, hang guard, shared tasks
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    pe = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bounded wait for one output condition, sampled at the edge
  task automatic wt(input int k);
    logic       hit;
    logic [5:0] v;
    hit = 1'b0;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(posedge clk);
      v = {homing_req, st == ST_DWELL, st == ST_IDLE, limit_stop,
           halt_req, cmd_load};
      hit = v[k];
    end
    chk(32'(hit), 32'h1);
  endtask : wt
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, trg, halt, flim, rlim, hpin, son} = '0;
    {paddr, pwdata, sel} = '0;
    {err_total, num_checks, cyc} = '0;
    lat = 8'd5;
    nrst = 1'b0;
    void'($urandom(32'h2f0a));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t1 = $urandom & 32'h00ff_ffff;
    apb(1, 12'h040, t1);
    apb(0, 12'h040, 0);
    chk(rd, {t1[31:4], 4'h0});
    apb(0, 12'hffc, 0);
    chk(32'(pe), 32'h1);
    t1 = $urandom;
    t2 = $urandom;
    sp = $urandom & 32'hffff;
    apb(1, 12'h080, sp);
    apb(1, 12'h100, 32'h2);
    apb(1, 12'h040, 32'h0);
    apb(1, 12'h044, t1);
    apb(1, 12'h048, 32'h80);
    apb(1, 12'h04c, t2);
    apb(1, 12'h008, 32'h1);
    wt(0);
    chk(cmd.end_pos, t1);
    chk(32'(cmd.speed), sp);
    wt(4);
    wt(3);
    @(posedge clk);
    sel <= 6'd2;
    repeat (2) @(posedge clk);
    trg <= 1'b1;
    wt(0);
    chk(cmd.end_pos, t1 + t2);
    trg <= 1'b0;
    wt(3);
    // Interrupted route, then a halt edge
    lat <= 8'd200;
    apb(1, 12'h048, 32'h90);
    apb(1, 12'h008, 32'h1);
    wt(0);
    apb(1, 12'h008, 32'h2);
    wt(0);
    chk(cmd.end_pos, t1 + t2);
    halt <= 1'b1;
    wt(1);
    wt(3);
    halt <= 1'b0;
    apb(1, 12'h008, 32'h1);
    wt(0);
    flim <= 1'b1;
    wt(2);
    // Homing: stop mode with limit high, then follow-on route 3
    apb(1, 12'h004, t2);
    apb(1, 12'h050, 32'h0);
    apb(1, 12'h054, t2);
    lat <= 8'd20;
    for (int p = 0; p < 2; p++) begin
      apb(1, 12'h000, {24'h0, 4'(3 * p), 4'h0});
      apb(1, 12'h008, 32'h0);
      wt(5);
      flim <= 1'b0;
      if (p == 0) wt(3);
      else wt(0);
      chk(32'(act), 32'(3 * p));
      chk(cmd.end_pos, t2);
      chk(32'(limit_stop), 32'h0);
    end
    // Overlap blend, then a pending speed route after a dwell
    wt(3);
    apb(1, 12'h058, 32'h20);
    apb(1, 12'h05c, t1);
    apb(1, 12'h060, 32'h0);
    apb(1, 12'h064, t2);
    apb(1, 12'h068, 32'h40);
    apb(1, 12'h008, 32'h4);
    wt(0);
    c0 = cyc;
    apb(1, 12'h008, 32'h5);
    wt(0);
    chk(cyc - c0, 32'(lat) + 32'd2);
    chk(32'(cmd.blend), 32'h1);
    chk(cmd.end_pos, t2);
    c0 = cyc;
    apb(1, 12'h008, 32'h6);
    wt(0);
    chk(cyc - c0, 32'(lat) + 32'd2 + 32'd8);
    chk(32'(cmd.speed_mode), 32'h1);
    chk(cmd.end_pos, t2);
    // Boot homing: off leaves servo-on alone, on after a fresh reset
    wt(3);
    son <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(st), 32'(ST_IDLE));
    son  <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    apb(1, 12'h000, 32'h1);
    son <= 1'b1;
    wt(5);
    wt(3);
    stop_test();
  end
endmodule : motion_route_sequencer_tb
